/* File: core/sol_limiter.sv */
// Simultaneous output limiter with AHB-Lite register slave
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sol_limiter
	import sol_pkg::*;
#(
	parameter int          NUM_CH      = 4,
	parameter int unsigned TICK_CYCLES = sol_pkg::SOL_MS_CYCLES
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	// Actuator drive levels
	output logic [NUM_CH-1:0]      ctrl_out
);
	import sol_pkg::*;

	localparam int LOG_CH = $clog2(NUM_CH);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	// Permille of a period, in whole milliseconds
	function automatic logic [SOL_ACT_W-1:0] to_ms(input logic [SOL_MV_W-1:0] permille,
		input logic [SOL_ACT_W-1:0] period);
		logic [26:0] prod;
		logic [26:0] quot;
		prod = 27'(permille) * 27'(period);
		quot = prod / 27'd1000;
		return quot[SOL_ACT_W-1:0];
	endfunction : to_ms

	// Lesser of two millisecond counts
	function automatic logic [SOL_ACT_W-1:0] min_ms(input logic [SOL_ACT_W-1:0] a,
		input logic [SOL_ACT_W-1:0] b);
		return (a < b) ? a : b;
	endfunction : min_ms

	// Software settings
	logic [1:0]              mode;
	logic                    heat_cool;
	logic [SOL_DELAY_W-1:0]  delay_ms;
	logic [SOL_PERIOD_W-1:0] period   [NUM_CH];
	logic                    ch_enable[NUM_CH];
	logic                    ch_pid   [NUM_CH];
	logic [SOL_MV_W-1:0]     mv_in    [NUM_CH];
	logic [SOL_MV_W-1:0]     mv_upper [NUM_CH];
	logic [SOL_MV_W-1:0]     mv_lower [NUM_CH];

	// Bus pipeline state
	logic       wr_pend;
	logic       rd_pend;
	logic [7:0] addr_q;
	logic [31:0] next_rdata;

	// Millisecond enable
	logic [TICK_W-1:0] tick_cnt;
	logic              ms_tick;

	// Address phase and decode
	logic       addr_phase;
	logic       ch_hit;
	logic [1:0] ch_sel;
	logic [3:0] ch_reg;
	logic       onms_hit;
	logic [1:0] onms_sel;
	assign addr_phase = hsel && hready && htrans[1];
	assign ch_sel     = 2'(addr_q[5:4] - 2'h1);
	assign ch_reg     = addr_q[3:0];
	assign ch_hit     = (addr_q >= SOL_ADDR_CH0) && (addr_q < SOL_ADDR_CH_END)
		&& (32'(ch_sel) < 32'(NUM_CH));
	assign onms_sel   = addr_q[3:2];
	assign onms_hit   = (addr_q >= SOL_ADDR_ONMS0) && (addr_q < SOL_ADDR_ONMS_E)
		&& (32'(onms_sel) < 32'(NUM_CH));

	// Reads stall one cycle so a write just before is always seen
	assign hreadyout = !rd_pend;
	assign hresp     = 1'b0;

	// Restriction selection
	logic [1:0]           mode_eff;
	logic                 restrict_on;
	logic [1:0]           quarters;
	logic [SOL_ACT_W-1:0] delay_eff;
	logic [SOL_ACT_W-1:0] actual;
	logic [18:0]          share_prod;
	logic [SOL_ACT_W-1:0] share_ms;
	logic [SOL_ACT_W-1:0] ceiling_ms;

	// Two-channel unit treats three and two outputs as none
	assign mode_eff    = (NUM_CH == 2 && mode != SOL_MODE_ONE) ? SOL_MODE_NONE : mode; // RULE3
	assign restrict_on = (mode_eff != SOL_MODE_NONE) && !heat_cool; // RULE15
	// Ceiling in quarters of the actual period
	assign quarters    = (mode_eff == SOL_MODE_THREE) ? 2'h3 : // RULE2
		(mode_eff == SOL_MODE_TWO) ? 2'h2 :
		(NUM_CH == 2) ? 2'h2 : 2'h1; // RULE3
	assign delay_eff   = restrict_on ? SOL_ACT_W'(delay_ms) : '0; // RULE8
	// Stretched period, common to all channels while restricted
	assign actual      = SOL_ACT_W'(period[0]) + SOL_ACT_W'(delay_eff * SOL_ACT_W'(NUM_CH)); // RULE5 RULE10
	assign share_prod  = 19'(actual) * 19'(quarters);
	assign share_ms    = share_prod[18:2];
	// Delay comes out of each slot, leaving the forced OFF gap
	assign ceiling_ms  = (share_ms > delay_eff) ? share_ms - delay_eff : '0; // RULE4 RULE9

	// Per-channel scheduling
	logic [SOL_ACT_W-1:0] ch_period[NUM_CH];
	logic [SOL_ACT_W-1:0] phase    [NUM_CH];
	logic [SOL_ACT_W-1:0] offset   [NUM_CH];
	logic [SOL_ACT_W-1:0] pos      [NUM_CH];
	logic [SOL_ACT_W-1:0] on_ms    [NUM_CH];
	logic [NUM_CH-1:0]    next_out;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic [18:0]          off_prod;
			logic [18:0]          off_shift;
			logic [SOL_MV_W-1:0]  mv_floor;
			logic [SOL_MV_W-1:0]  mv_clamp;
			logic [SOL_ACT_W-1:0] base_ms;
			logic                 limited;

			// Own period unless restricted
			assign ch_period[g] = restrict_on ? actual : SOL_ACT_W'(period[g]); // RULE5
			// Stagger by half or quarter of the actual period
			assign off_prod     = 19'(actual) * 19'(g);
			assign off_shift    = off_prod >> LOG_CH;
			assign offset[g]    = off_shift[SOL_ACT_W-1:0]; // RULE1
			// Position within the staggered slot
			assign pos[g]       = !restrict_on ? phase[g] :
				(phase[0] >= offset[g]) ? phase[0] - offset[g] :
				phase[0] + actual - offset[g]; // RULE1
			// Clamp to lower then upper limit
			assign mv_floor     = (mv_in[g] < mv_lower[g]) ? mv_lower[g] : mv_in[g];
			assign mv_clamp     = (mv_floor > mv_upper[g]) ? mv_upper[g] : mv_floor; // RULE6
			assign base_ms      = to_ms(mv_clamp, ch_period[g]);
			assign limited      = restrict_on && ch_pid[g]; // RULE16
			// Lower limit above ceiling falls out of the min as the ceiling
			assign on_ms[g]     = !ch_enable[g] ? '0 : // RULE11
				limited ? min_ms(base_ms, ceiling_ms) : base_ms; // RULE6 RULE7
			assign next_out[g]  = pos[g] < on_ms[g]; // RULE17

			sol_phase_counter u_phase (
				.sys_clk  (sys_clk),
				.reset_n  (reset_n),
				.ms_tick  (ms_tick),
				.period_ms(ch_period[g]),
				.phase    (phase[g])
			);
		end
	endgenerate

	// Millisecond divider
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end else if (32'(tick_cnt) >= TICK_CYCLES - 1) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + TICK_W'(1);
			ms_tick  <= 1'b0;
		end
	end

	// Registered drive levels
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_out <= '0;
		end else begin
			ctrl_out <= next_out; // RULE17
		end
	end

	// Bus pipeline: capture address phase, stall reads one cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= '0;
		end else begin
			wr_pend <= addr_phase && hwrite;
			rd_pend <= addr_phase && !hwrite;
			if (addr_phase) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// Read data captured in the stall cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			hrdata <= '0;
		end else if (rd_pend) begin
			hrdata <= next_rdata;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (addr_q == SOL_ADDR_CTRL) begin
			next_rdata = {29'h0, heat_cool, mode};
		end else if (addr_q == SOL_ADDR_DELAY) begin
			next_rdata = {22'h0, delay_ms};
		end else if (addr_q == SOL_ADDR_STATUS) begin
			next_rdata = {23'h0, restrict_on, 8'(ctrl_out)};
		end else if (addr_q == SOL_ADDR_ACTUAL) begin
			next_rdata = {15'h0, ch_period[0]};
		end else if (ch_hit && ch_reg == SOL_CH_PERIOD) begin
			next_rdata = {16'h0, period[ch_sel]};
		end else if (ch_hit && ch_reg == SOL_CH_CFG) begin
			next_rdata = {30'h0, ch_pid[ch_sel], ch_enable[ch_sel]};
		end else if (ch_hit && ch_reg == SOL_CH_MV) begin
			next_rdata = {22'h0, mv_in[ch_sel]};
		end else if (ch_hit && ch_reg == SOL_CH_LIMITS) begin
			next_rdata = {6'h0, mv_lower[ch_sel], 6'h0, mv_upper[ch_sel]};
		end else if (onms_hit) begin
			next_rdata = {15'h0, on_ms[onms_sel]};
		end
	end

	// Global settings; delay saturates at its top value
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode      <= SOL_RST_MODE; // RULE13
			heat_cool <= 1'b0;
			delay_ms  <= SOL_RST_DELAY; // RULE14
		end else if (wr_pend && addr_q == SOL_ADDR_CTRL) begin
			mode      <= hwdata[1:0]; // RULE13
			heat_cool <= hwdata[SOL_CTRL_HEATCOOL_BIT];
		end else if (wr_pend && addr_q == SOL_ADDR_DELAY) begin
			delay_ms  <= (hwdata[31:0] > 32'(SOL_DELAY_MAX)) ? SOL_DELAY_MAX :
				hwdata[SOL_DELAY_W-1:0]; // RULE14
		end
	end

	// Per-channel settings; MV values above full scale saturate
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				period[i]    <= SOL_RST_PERIOD;
				ch_enable[i] <= 1'b0;
				ch_pid[i]    <= 1'b1;
				mv_in[i]     <= '0;
				mv_upper[i]  <= SOL_RST_UPPER;
				mv_lower[i]  <= SOL_RST_LOWER;
			end
		end else if (wr_pend && ch_hit) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (ch_sel == 2'(i)) begin
					if (ch_reg == SOL_CH_PERIOD) begin
						period[i] <= hwdata[SOL_PERIOD_W-1:0];
					end else if (ch_reg == SOL_CH_CFG) begin
						ch_enable[i] <= hwdata[SOL_CFG_ENABLE_BIT];
						ch_pid[i]    <= hwdata[SOL_CFG_PID_BIT];
					end else if (ch_reg == SOL_CH_MV) begin
						mv_in[i] <= (hwdata[15:0] > 16'(SOL_MV_FULL)) ? SOL_MV_FULL :
							hwdata[SOL_MV_W-1:0];
					end else if (ch_reg == SOL_CH_LIMITS) begin
						mv_upper[i] <= (hwdata[15:0] > 16'(SOL_MV_FULL)) ? SOL_MV_FULL :
							hwdata[SOL_MV_W-1:0];
						mv_lower[i] <= (hwdata[31:16] > 16'(SOL_MV_FULL)) ? SOL_MV_FULL :
							hwdata[SOL_LIM_LOWER_LSB+SOL_MV_W-1:SOL_LIM_LOWER_LSB];
					end
				end
			end
		end
	end

endmodule : sol_limiter

/* File: core/sol_pkg.sv */
// Constants, register map and reset values of the simultaneous output limiter
// Behaviour
// RULE1: Restricted mode staggers channel period starts by half (2 ch) or quarter (4 ch).
// RULE2: Four channels: ceiling 100% none, 75% three, 50% two, 25% one output.
// RULE3: Two channels: three/two-output act unrestricted; one-output caps each at 50%.
// RULE4: Nonzero delay lowers each ceiling by one delay interval of the actual period.
// RULE5: Restricted timing uses channel one period for all channels, whatever its state.
// RULE6: Limited channel drive is the lesser of its upper limit and the ceiling.
// RULE7: Lower limit above the ceiling holds the channel at the ceiling.
// RULE8: Delay between outputs applies only while a restriction is selected.
// RULE9: A configured delay inserts a forced OFF gap between consecutive channel slots.
// RULE10: Actual period equals set period plus one delay per channel.
// RULE11: A disabled channel always drives 0.0%, whatever the ceiling.
// RULE12: Software should pick the restriction before autotuning the loops.
// RULE13: Restriction code 0 none, 1 three, 2 two, 3 one output; default 0.
// RULE14: Delay between outputs ranges 0 to 1000 ms, default 10 ms.
// RULE15: Heating-and-cooling variants never apply the limit.
// RULE16: The limit applies only to channels under PID control.
// RULE17: Each output is ON for its clamped fraction of the period within its slot.
package sol_pkg;

	// Timing
	localparam int unsigned SOL_CLK_PERIOD_NS = 10;
	localparam int unsigned SOL_MS_NS         = 1000000;
	localparam int unsigned SOL_MS_CYCLES     = SOL_MS_NS / SOL_CLK_PERIOD_NS;

	// Field widths
	localparam int SOL_PERIOD_W = 16;
	localparam int SOL_ACT_W    = 17;
	localparam int SOL_MV_W     = 10;
	localparam int SOL_DELAY_W  = 10;

	// Restriction codes
	localparam logic [1:0] SOL_MODE_NONE  = 2'h0;
	localparam logic [1:0] SOL_MODE_THREE = 2'h1;
	localparam logic [1:0] SOL_MODE_TWO   = 2'h2;
	localparam logic [1:0] SOL_MODE_ONE   = 2'h3;

	// Register byte addresses
	localparam logic [7:0] SOL_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] SOL_ADDR_DELAY  = 8'h04;
	localparam logic [7:0] SOL_ADDR_STATUS = 8'h08;
	localparam logic [7:0] SOL_ADDR_ACTUAL = 8'h0c;
	localparam logic [7:0] SOL_ADDR_CH0    = 8'h10;
	localparam logic [7:0] SOL_ADDR_CH_END = 8'h50;
	localparam logic [7:0] SOL_ADDR_ONMS0  = 8'h50;
	localparam logic [7:0] SOL_ADDR_ONMS_E = 8'h60;

	// Offsets inside a channel block
	localparam logic [3:0] SOL_CH_PERIOD = 4'h0;
	localparam logic [3:0] SOL_CH_CFG    = 4'h4;
	localparam logic [3:0] SOL_CH_MV     = 4'h8;
	localparam logic [3:0] SOL_CH_LIMITS = 4'hc;

	// Field positions
	localparam int SOL_CTRL_HEATCOOL_BIT = 2;
	localparam int SOL_CFG_ENABLE_BIT    = 0;
	localparam int SOL_CFG_PID_BIT       = 1;
	localparam int SOL_LIM_LOWER_LSB     = 16;
	localparam int SOL_STAT_RESTRICT_BIT = 8;

	// Reset values and ranges
	localparam logic [1:0]              SOL_RST_MODE   = SOL_MODE_NONE;
	localparam logic [SOL_DELAY_W-1:0]  SOL_RST_DELAY  = 10'h00a;
	localparam logic [SOL_DELAY_W-1:0]  SOL_DELAY_MAX  = 10'h3e8;
	localparam logic [SOL_PERIOD_W-1:0] SOL_RST_PERIOD = 16'h07d0;
	localparam logic [SOL_MV_W-1:0]     SOL_MV_FULL    = 10'h3e8;
	localparam logic [SOL_MV_W-1:0]     SOL_RST_UPPER  = 10'h3e8;
	localparam logic [SOL_MV_W-1:0]     SOL_RST_LOWER  = 10'h000;

endpackage : sol_pkg

/* File: core/sol_phase_counter.sv */
// Millisecond phase counter of one control period
`timescale 1ns/1ps
module sol_phase_counter
	import sol_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset_n,
	// Timing
	input  wire logic                 ms_tick,
	input  wire logic [SOL_ACT_W-1:0] period_ms,
	// Position in period
	output logic      [SOL_ACT_W-1:0] phase
);
	import sol_pkg::*;

	// Wrap on the last millisecond; a shortened period also wraps at once
	logic wrap;
	assign wrap = ({1'b0, phase} + 18'h00001) >= {1'b0, period_ms};

	// Count only on the millisecond enable
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			phase <= '0;
		end else if (ms_tick) begin
			phase <= wrap ? '0 : phase + 17'h00001;
		end
	end

endmodule : sol_phase_counter

/* File: verification/sol_limiter_monitor.sv */
// Bus timing and output overlap checker of the simultaneous output limiter
`timescale 1ns/1ps
module sol_limiter_monitor #(
	parameter int          NUM_CH      = 4,
	parameter int unsigned TICK_CYCLES = 10
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	input  wire logic              hreadyout,
	input  wire logic [31:0]       hrdata,
	input  wire logic              hresp,
	// Actuator drive levels
	input  wire logic [NUM_CH-1:0] ctrl_out
);
	localparam int unsigned SETTLE = 2 * TICK_CYCLES + 4;
	logic        wp;
	logic [7:0]  wa;
	logic [2:0]  ctrl_s;
	logic [3:0]  en_s;
	logic [3:0]  pid_s;
	int unsigned quiet;
	logic        wr_now;
	logic        cfg_hit;
	logic        lim_on;
	assign wr_now  = wp && hready;
	assign cfg_hit = wa[3:0] == 4'h4 && wa[7:4] != 4'h0 && int'(wa[7:4]) <= NUM_CH;
	// Settings only count once two ticks and four cycles have passed since the last write
	assign lim_on  = quiet >= SETTLE && !ctrl_s[2] && (&pid_s[NUM_CH-1:0]);
	// Shadow of mode and channel configuration from observed writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wp     <= 1'b0;
			ctrl_s <= 3'h0;
			en_s   <= 4'h0;
			pid_s  <= 4'hf;
			quiet  <= 0;
		end else begin
			if (hready) wp <= hsel && htrans[1] && hwrite;
			if (hready) wa <= haddr[7:0];
			quiet <= wr_now ? 0 : (quiet < SETTLE ? quiet + 1 : quiet);
			if (wr_now && wa == 8'h00) ctrl_s <= hwdata[2:0];
			if (wr_now && cfg_hit) en_s[wa[5:4] - 2'h1] <= hwdata[0];
			if (wr_now && cfg_hit) pid_s[wa[5:4] - 2'h1] <= hwdata[1];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_read_req;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_write_req;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	a_okay_response: assert property (hresp == 1'b0)
		else $error("slave answered with an error response");
	a_read_wait_state: assert property (s_read_req |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
	a_write_no_wait: assert property (s_write_req |=> hreadyout)
		else $error("write data phase was stalled");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data changed outside a read stall");
	a_disabled_dark: assert property (quiet >= SETTLE |-> (ctrl_out & ~en_s[NUM_CH-1:0]) == 0)
		else $error("disabled channel drove its output");
	a_one_output_cap: assert property (lim_on && ctrl_s[1:0] == 2'h3 |-> $countones(ctrl_out) <= 1)
		else $error("more than one output on in one-output mode");
	a_two_output_cap: assert property (lim_on && NUM_CH == 4 && ctrl_s[1:0] == 2'h2 |-> $countones(ctrl_out) <= 2)
		else $error("more than two outputs on in two-output mode");
	a_three_output_cap: assert property (lim_on && NUM_CH == 4 && ctrl_s[1:0] == 2'h1 |-> $countones(ctrl_out) <= 3)
		else $error("more than three outputs on in three-output mode");
endmodule : sol_limiter_monitor

bind sol_limiter sol_limiter_monitor #(.NUM_CH(NUM_CH), .TICK_CYCLES(TICK_CYCLES)) i_monitor (
	.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .ctrl_out(ctrl_out));

/* File: verification/sol_actuator_model.sv */
// Bank of on/off actuators that records overlap, ON time, stagger and gaps
`timescale 1ns/1ps
module sol_actuator_model (
	// Clock and window restart
	input  wire logic        sys_clk,
	input  wire logic        clear,
	// Drive levels
	input  wire logic [3:0]  ctrl_out,
	// Observations
	output logic      [2:0]  max_on,
	output logic      [15:0] on_sum,
	output logic      [15:0] lag,
	output logic      [15:0] min_gap
);
	logic [3:0]  prev = 4'h0;
	logic [15:0] since = 16'h0;
	logic [15:0] idle;
	logic [2:0]  now_on;
	assign now_on = 3'($countones(ctrl_out));
	// Contacts follow the drive level; all stats restart on clear
	always @(posedge sys_clk) begin
		if (clear) begin
			max_on  <= 3'h0;
			on_sum  <= 16'h0;
			lag     <= 16'h0;
			min_gap <= 16'hffff;
			idle    <= 16'h0;
		end else begin
			if (now_on > max_on) max_on <= now_on;
			on_sum <= on_sum + 16'(now_on);
			if (ctrl_out[1] && !prev[1]) lag <= since;
			idle <= (|ctrl_out) ? 16'h0 : idle + 16'h1;
			if ((|ctrl_out) && idle != 16'h0 && idle < min_gap) min_gap <= idle;
		end
		since <= (ctrl_out[0] && !prev[0]) ? 16'h1 : since + 16'h1;
		prev  <= ctrl_out;
	end
endmodule : sol_actuator_model

/* File: verification/tb_sol_limiter.sv */
// Self-checking bench of the simultaneous output limiter
`timescale 1ns/1ps
module tb_sol_limiter;
	import sol_pkg::*;
	localparam int          TICK = 10;
	localparam logic [31:0] P    = 32'h28;
	localparam logic [31:0] D    = 32'h2;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0;
	logic        clear   = 1'b0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [3:0]  ctrl_out;
	logic [2:0]  max_on;
	logic [15:0] on_sum;
	logic [15:0] lag;
	logic [15:0] min_gap;
	int          err_count  = 0;
	int          num_checks = 0;

	always #5 sys_clk = ~sys_clk;

	sol_limiter #(.NUM_CH(4), .TICK_CYCLES(TICK)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .ctrl_out(ctrl_out));
	sol_actuator_model i_act (.sys_clk(sys_clk), .clear(clear), .ctrl_out(ctrl_out),
		.max_on(max_on), .on_sum(on_sum), .lag(lag), .min_gap(min_gap));

	task finish_test;
		if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Ready is judged on its settled value, then the edge is taken
	task wait_ready;
		@(negedge sys_clk);
		while (hreadyout !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
	endtask : wait_ready

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		q = hrdata;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rdc

	// Live settings take hold at the next millisecond tick
	task settle;
		repeat (2 * TICK + 4) @(posedge sys_clk);
	endtask : settle

	function automatic logic [7:0] cha(input int n, input logic [3:0] off);
		return SOL_ADDR_CH0 + 8'(16 * n) + {4'h0, off};
	endfunction : cha

	function automatic logic [7:0] onms(input int n);
		return SOL_ADDR_ONMS0 + 8'(4 * n);
	endfunction : onms

	initial begin
		#500000;
		err_count++;
		finish_test;
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rdc(SOL_ADDR_CTRL, 32'h0);
		rdc(SOL_ADDR_DELAY, 32'(SOL_RST_DELAY));
		rdc(8'hfc, 32'h0);
		wr(SOL_ADDR_DELAY, 32'h7d0);
		rdc(SOL_ADDR_DELAY, 32'(SOL_DELAY_MAX));
		for (int n = 0; n < 4; n++) begin
			wr(cha(n, SOL_CH_CFG), 32'h3);
			wr(cha(n, SOL_CH_MV), 32'(SOL_MV_FULL));
			wr(cha(n, SOL_CH_PERIOD), (n == 0) ? P : 32'h64);
		end
		settle;
		rdc(SOL_ADDR_ACTUAL, P);
		rdc(onms(1), 32'h64);
		wr(SOL_ADDR_DELAY, 32'h0);
		// Each restriction code against its quarter ceiling
		for (int m = 1; m < 4; m++) begin
			wr(SOL_ADDR_CTRL, 32'(m));
			settle;
			rdc(onms(0), 32'(P * (4 - m) / 4));
			rdc(onms(1), 32'(P * (4 - m) / 4));
		end
		wr(SOL_ADDR_DELAY, D);
		settle;
		rdc(SOL_ADDR_ACTUAL, P + 4 * D);
		rdc(onms(2), (P + 4 * D) / 4 - D);
		bus(1'b0, SOL_ADDR_STATUS, 32'h0);
		chk(32'(q[8]), 32'h1);
		// One full actual period watched at the actuators
		@(negedge sys_clk iff ctrl_out[0] === 1'b1);
		@(posedge sys_clk);
		clear <= 1'b1;
		@(posedge sys_clk);
		clear <= 1'b0;
		repeat (TICK * (P + 4 * D)) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(max_on), 32'h1);
		chk(32'(on_sum), 4 * TICK * ((P + 4 * D) / 4 - D));
		chk(32'(lag), TICK * (P + 4 * D) / 4);
		chk(32'(min_gap), TICK * D);
		@(posedge sys_clk);
		wr(cha(0, SOL_CH_CFG), 32'h2);
		settle;
		rdc(SOL_ADDR_ACTUAL, P + 4 * D);
		rdc(onms(0), 32'h0);
		wr(SOL_ADDR_DELAY, 32'h0);
		wr(cha(2, SOL_CH_LIMITS), 32'h0c8);
		wr(cha(3, SOL_CH_LIMITS), 32'h01f403e8);
		wr(cha(3, SOL_CH_MV), 32'h0);
		settle;
		rdc(onms(2), 32'h0c8 * P / 32'h3e8);
		rdc(onms(3), P / 4);
		// A channel outside PID control escapes the ceiling
		wr(cha(1, SOL_CH_CFG), 32'h1);
		settle;
		rdc(onms(1), P);
		wr(SOL_ADDR_CTRL, 32'h7);
		settle;
		rdc(onms(1), 32'h64);
		finish_test;
	end
endmodule : tb_sol_limiter
